// ===== cddf_bit_tx.sv
// bit serializer driving the clock and data lines of the link
// assumes the framer holds off a new request until done_ff pulses
module cddf_bit_tx #(
	parameter int PHASE_CYCLES = cddf_pkg::PHASE_CYC
)
(
	input  logic                   clk,
	input  logic                   reset_n,
	input  logic                   req,
	input  cddf_pkg::cddf_sym_type sym,
	output logic                   done_ff,
	output logic                   line_clk_ff,
	output logic                   line_data_ff
);
	import cddf_pkg::*;

	// ----------------------------------------
	// phase sequencing
	// ----------------------------------------
	cddf_phase_type     phase_ff;
	cddf_phase_type     nxt_phase;
	logic [PAT_W-1:0]   shift_ff;
	logic [PAT_W-1:0]   nxt_shift;
	logic [4:0]         left_ff;
	logic [4:0]         nxt_left;
	logic [PHASE_W-1:0] cnt_ff;
	logic [PHASE_W-1:0] low_cnt_ff;

	wire                phase_end     = (cnt_ff == PHASE_W'(PHASE_CYCLES - 1));
	wire                last_bit      = (left_ff == 5'h01);
	wire [PHASE_W-1:0]  nxt_cnt       = (phase_ff == PH_IDLE || phase_end) ? '0 : cnt_ff + 1'b1;
	wire                nxt_done      = (phase_ff == PH_HOLD) && phase_end && last_bit;
	wire                nxt_line_clk  = (nxt_phase != PH_LOW);
	wire                nxt_line_data = (nxt_phase == PH_IDLE) | ~nxt_shift[0];
	wire [PHASE_W-1:0]  nxt_low_cnt   = line_clk_ff ? '0 : low_cnt_ff + 1'b1;

	always_comb
	begin
		nxt_phase = phase_ff;
		nxt_shift = shift_ff;
		nxt_left  = left_ff;
		case (phase_ff)
			PH_IDLE:
			begin
				if (req)
				begin
					nxt_phase = PH_SETUP;
					nxt_shift = sym.pat;
					nxt_left  = sym.len;
				end
			end
			PH_SETUP:
			begin
				if (phase_end)
					nxt_phase = PH_LOW;
			end
			PH_LOW:
			begin
				if (phase_end)
					nxt_phase = PH_HOLD;
			end
			PH_HOLD:
			begin
				if (phase_end)
				begin
					nxt_shift = shift_ff >> 1;
					nxt_left  = left_ff - 5'h01;
					nxt_phase = last_bit ? PH_IDLE : PH_SETUP;
				end
			end
			default:
				nxt_phase = PH_IDLE;
		endcase
	end

	// ----------------------------------------
	// registers; clock active low, data inverted
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			phase_ff     <= PH_IDLE;
			shift_ff     <= '0;
			left_ff      <= '0;
			cnt_ff       <= '0;
			low_cnt_ff   <= '0;
			done_ff      <= 1'b0;
			line_clk_ff  <= 1'b1;
			line_data_ff <= 1'b1;
		end
		else
		begin
			phase_ff     <= nxt_phase;
			shift_ff     <= nxt_shift;
			left_ff      <= nxt_left;
			cnt_ff       <= nxt_cnt;
			low_cnt_ff   <= nxt_low_cnt;
			done_ff      <= nxt_done;
			line_clk_ff  <= nxt_line_clk;
			line_data_ff <= nxt_line_data;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_idle_lines_high: assert property (
		@(posedge clk) disable iff (!reset_n)
		(phase_ff == PH_IDLE) |-> (line_clk_ff && line_data_ff))
		else $error("lines not high while idle");

	chk_low_phase_len: assert property (
		@(posedge clk) disable iff (!reset_n)
		$rose(line_clk_ff) |-> (low_cnt_ff == PHASE_W'(PHASE_CYCLES)))
		else $error("clock low phase has wrong length");

	chk_data_steady_low: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!line_clk_ff && !$past(line_clk_ff)) |-> $stable(line_data_ff))
		else $error("data moved while clock low");

endmodule

// ===== cddf_framer.sv
// clock/data digit framer: translates card digits and frames them
// assumes digit source on clk; led inputs and panel are asynchronous
module cddf_framer #(
	parameter int PHASE_CYCLES = cddf_pkg::PHASE_CYC
)
(
	input  logic                     clk,
	input  logic                     reset_n,
	input  logic                     frame_start,
	input  logic [7:0]               cfg,
	input  logic                     digit_valid,
	input  cddf_pkg::cddf_digit_type digit,
	input  logic [1:0]               led_req_n,
	output logic                     digit_ready_ff,
	output logic                     busy_ff,
	output logic                     line_clk_ff,
	output logic                     line_data_ff,
	output logic [1:0]               led_on_ff
);
	import cddf_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	cddf_frame_state_type state_ff;
	cddf_frame_state_type nxt_state;
	logic [7:0]           cfg_ff;
	logic [3:0]           q0_ff;
	logic [3:0]           q1_ff;
	logic [1:0]           qcnt_ff;
	logic                 qlast_ff;
	logic [3:0]           lrc_ff;
	logic                 wait_ff;
	logic                 tx_req_ff;
	cddf_sym_type         tx_sym_ff;
	logic [3:0]           nxt_q0;
	logic [3:0]           nxt_q1;
	logic [1:0]           nxt_qcnt;
	logic                 nxt_qlast;
	logic [3:0]           nxt_lrc;
	logic                 issue;
	cddf_sym_type         nxt_sym;
	logic [1:0]           t_cnt;
	logic [3:0]           t0;
	logic [3:0]           t1;
	logic                 tx_done;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire       raw_mode    = cfg_ff[CFG_RAW_BIT];
	wire [1:0] xl_code     = cfg_ff[CFG_XL_HI:CFG_XL_LO];
	wire       can_issue   = !wait_ff;
	wire       take        = digit_ready_ff && digit_valid;
	wire [3:0] dval        = digit.value;
	wire       dig_big     = (dval > DIG_MAX);
	wire [3:0] dig_mod     = dval - DIG_TEN;
	wire       start_ok    = frame_start && (state_ff == ST_IDLE);
	wire       nxt_wait    = issue | (wait_ff & ~tx_done);
	wire       nxt_busy    = (nxt_state != ST_IDLE);
	wire       nxt_ready   = (nxt_state == ST_CONTENT) && (nxt_qcnt == 2'h0) && !nxt_qlast;
	wire [3:0] after_state = raw_mode ? 4'h0 : 4'h1;
	wire       go_stop     = (after_state != 4'h0);

	// ----------------------------------------
	// digit translation
	// ----------------------------------------
	always_comb
	begin
		t_cnt = 2'h1;
		t0    = dval;
		t1    = DIG_ZERO;
		if (raw_mode)
		begin
			t_cnt = 2'h1;
		end
		else if (xl_code == XL_DEC2)
		begin
			t_cnt = 2'h2;
			t0    = dig_big ? DIG_ONE : DIG_ZERO;
			t1    = dig_big ? dig_mod : dval;
		end
		else if (dig_big)
		begin
			case (xl_code)
				XL_DROP:
				begin
					t_cnt = 2'h0;
				end
				XL_SEP:
				begin
					t0 = DIG_SEP;
				end
				XL_SEPMOD:
				begin
					t_cnt = 2'h2;
					t0    = DIG_SEP;
					t1    = dig_mod;
				end
				default:
				begin
					t_cnt = 2'h0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// frame sequencing
	// ----------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_q0    = q0_ff;
		nxt_q1    = q1_ff;
		nxt_qcnt  = qcnt_ff;
		nxt_qlast = qlast_ff;
		nxt_lrc   = lrc_ff;
		issue     = 1'b0;
		nxt_sym   = tx_sym_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (start_ok)
				begin
					nxt_lrc   = DIG_ZERO;
					nxt_qlast = 1'b0;
					nxt_qcnt  = 2'h0;
					nxt_state = cfg[CFG_RAW_BIT] ? ST_CONTENT : ST_LEAD;
				end
			end
			ST_LEAD:
			begin
				if (can_issue)
				begin
					issue       = 1'b1;
					nxt_sym.pat = '0;
					nxt_sym.len = LEN_RUN;
					nxt_state   = ST_START;
				end
			end
			ST_START:
			begin
				if (can_issue)
				begin
					issue     = 1'b1;
					nxt_sym   = cddf_encode(DIG_START);
					nxt_lrc   = lrc_ff ^ DIG_START;
					nxt_state = ST_CONTENT;
				end
			end
			ST_CONTENT:
			begin
				if (take)
				begin
					nxt_q0    = t0;
					nxt_q1    = t1;
					nxt_qcnt  = t_cnt;
					nxt_qlast = digit.last;
					if (t_cnt == 2'h0 && digit.last)
						nxt_state = go_stop ? ST_STOP : ST_DONE;
				end
				else if (qcnt_ff != 2'h0 && can_issue)
				begin
					issue    = 1'b1;
					nxt_sym  = cddf_encode(q0_ff);
					nxt_lrc  = lrc_ff ^ q0_ff;
					nxt_q0   = q1_ff;
					nxt_qcnt = qcnt_ff - 2'h1;
					if (qcnt_ff == 2'h1 && qlast_ff)
						nxt_state = go_stop ? ST_STOP : ST_DONE;
				end
			end
			ST_STOP:
			begin
				if (can_issue)
				begin
					issue     = 1'b1;
					nxt_sym   = cddf_encode(DIG_STOP);
					nxt_state = ST_LRC;
				end
			end
			ST_LRC:
			begin
				if (can_issue)
				begin
					issue     = 1'b1;
					nxt_sym   = cddf_encode(lrc_ff);
					nxt_state = ST_TRAIL;
				end
			end
			ST_TRAIL:
			begin
				if (can_issue)
				begin
					issue       = 1'b1;
					nxt_sym.pat = '0;
					nxt_sym.len = LEN_RUN;
					nxt_state   = ST_DONE;
				end
			end
			ST_DONE:
			begin
				if (!wait_ff)
					nxt_state = ST_IDLE;
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state_ff       <= ST_IDLE;
			cfg_ff         <= '0;
			q0_ff          <= '0;
			q1_ff          <= '0;
			qcnt_ff        <= '0;
			qlast_ff       <= 1'b0;
			lrc_ff         <= '0;
			wait_ff        <= 1'b0;
			tx_req_ff      <= 1'b0;
			tx_sym_ff      <= '0;
			digit_ready_ff <= 1'b0;
			busy_ff        <= 1'b0;
		end
		else
		begin
			state_ff       <= nxt_state;
			cfg_ff         <= start_ok ? cfg : cfg_ff;
			q0_ff          <= nxt_q0;
			q1_ff          <= nxt_q1;
			qcnt_ff        <= nxt_qcnt;
			qlast_ff       <= nxt_qlast;
			lrc_ff         <= nxt_lrc;
			wait_ff        <= nxt_wait;
			tx_req_ff      <= issue;
			tx_sym_ff      <= nxt_sym;
			digit_ready_ff <= nxt_ready;
			busy_ff        <= nxt_busy;
		end
	end

	// ----------------------------------------
	// line serializer
	// ----------------------------------------
	cddf_bit_tx #(
		.PHASE_CYCLES (PHASE_CYCLES)
	) u_bit_tx (
		.clk          (clk),
		.reset_n      (reset_n),
		.req          (tx_req_ff),
		.sym          (tx_sym_ff),
		.done_ff      (tx_done),
		.line_clk_ff  (line_clk_ff),
		.line_data_ff (line_data_ff)
	);

	// ----------------------------------------
	// led inputs, low lights the indicator
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < LED_NUM; i++)
		begin : g_led
			logic meta_ff;
			logic sync_ff;
			always_ff @(posedge clk)
			begin
				if (!reset_n)
				begin
					meta_ff      <= 1'b1;
					sync_ff      <= 1'b1;
					led_on_ff[i] <= 1'b0;
				end
				else
				begin
					meta_ff      <= led_req_n[i];
					sync_ff      <= meta_ff;
					led_on_ff[i] <= ~sync_ff;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_symbol_odd_parity: assert property (
		@(posedge clk) disable iff (!reset_n)
		(tx_req_ff && tx_sym_ff.len == LEN_SYM) |-> (^tx_sym_ff.pat[4:0]))
		else $error("symbol parity is not odd");

	chk_lead_zero_run: assert property (
		@(posedge clk) disable iff (!reset_n)
		(tx_req_ff && $past(state_ff) == ST_LEAD)
			|-> (tx_sym_ff.pat == '0 && tx_sym_ff.len == LEN_RUN && state_ff == ST_START))
		else $error("leading run malformed");

	chk_start_sentinel: assert property (
		@(posedge clk) disable iff (!reset_n)
		(tx_req_ff && $past(state_ff) == ST_START) |-> (tx_sym_ff == cddf_encode(DIG_START)))
		else $error("start sentinel wrong");

	chk_stop_sentinel: assert property (
		@(posedge clk) disable iff (!reset_n)
		(tx_req_ff && $past(state_ff) == ST_STOP)
			|-> (tx_sym_ff == cddf_encode(DIG_STOP) && state_ff == ST_LRC))
		else $error("stop sentinel wrong");

	chk_stripe_decimal: assert property (
		@(posedge clk) disable iff (!reset_n)
		(tx_req_ff && !raw_mode && $past(state_ff) == ST_CONTENT)
			|-> (tx_sym_ff.pat[3:0] <= DIG_MAX || tx_sym_ff.pat[3:0] == DIG_SEP))
		else $error("non decimal digit in stripe frame");

	chk_raw_no_framing: assert property (
		@(posedge clk) disable iff (!reset_n)
		(raw_mode && state_ff != ST_IDLE) |-> (state_ff == ST_CONTENT || state_ff == ST_DONE))
		else $error("raw frame entered framing state");

	chk_busy_lines_idle: assert property (
		@(posedge clk) disable iff (!reset_n)
		!busy_ff |-> (line_clk_ff && line_data_ff && !wait_ff))
		else $error("line active while not busy");

endmodule

// ===== cddf_framer_tb_top.sv
// self-checking bench for the digit framer
// assumes a short phase parameter so whole frames fit in a short run
module cddf_framer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import cddf_pkg::*;

	localparam int PH = 4;

	logic           clk;
	logic           reset_n;
	logic           frame_start;
	logic [7:0]     cfg;
	logic           digit_valid;
	cddf_digit_type digit;
	logic [1:0]     led_req_n;
	logic           digit_ready_ff;
	logic           busy_ff;
	logic           line_clk_ff;
	logic           line_data_ff;
	logic [1:0]     led_on_ff;
	logic           bit_seen_ff;
	logic           bit_val_ff;
	logic           exp_q[$];
	logic [3:0]     dig_q[$];
	logic [3:0]     lrc_acc;
	logic [7:0]     cfgs[6];
	int             fail_count;
	int             cmp_count;

	always #10 clk = ~clk;

	cddf_framer #(.PHASE_CYCLES(PH)) dut
	(
		.clk            (clk),
		.reset_n        (reset_n),
		.frame_start    (frame_start),
		.cfg            (cfg),
		.digit_valid    (digit_valid),
		.digit          (digit),
		.led_req_n      (led_req_n),
		.digit_ready_ff (digit_ready_ff),
		.busy_ff        (busy_ff),
		.line_clk_ff    (line_clk_ff),
		.line_data_ff   (line_data_ff),
		.led_on_ff      (led_on_ff)
	);

	cddf_panel_model panel
	(
		.clk         (clk),
		.reset_n     (reset_n),
		.line_clk    (line_clk_ff),
		.line_data   (line_data_ff),
		.bit_seen_ff (bit_seen_ff),
		.bit_val_ff  (bit_val_ff)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic timeout;
		fail_count++;
		$display("BAD %0t wait bound used up", $time);
		results();
	endtask

	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	task automatic push_sym(input logic [3:0] d);
		for (int b = 0; b < 4; b++)
			exp_q.push_back(d[b]);
		exp_q.push_back(~^d);
	endtask

	task automatic add(input logic [3:0] d);
		push_sym(d);
		lrc_acc = lrc_acc ^ d;
	endtask

	// expected line bits of one frame, noted before it is driven
	task automatic build(input logic [7:0] c);
		logic [3:0] v;
		if (c[CFG_RAW_BIT])
		begin
			foreach (dig_q[i])
				push_sym(dig_q[i]);
			return;
		end
		lrc_acc = 4'h0;
		repeat (16) exp_q.push_back(1'b0);
		add(DIG_START);
		foreach (dig_q[i])
		begin
			v = dig_q[i];
			case (c[CFG_XL_HI:CFG_XL_LO])
				XL_DROP: if (v <= DIG_MAX) add(v);
				XL_SEP: add(v > DIG_MAX ? DIG_SEP : v);
				XL_DEC2:
				begin
					add(v > DIG_MAX ? DIG_ONE : DIG_ZERO);
					add(v > DIG_MAX ? v - DIG_TEN : v);
				end
				default:
				begin
					if (v > DIG_MAX) add(DIG_SEP);
					add(v > DIG_MAX ? v - DIG_TEN : v);
				end
			endcase
		end
		// the stop sentinel is sent but stays out of the check digit
		push_sym(DIG_STOP);
		push_sym(lrc_acc);
		repeat (16) exp_q.push_back(1'b0);
	endtask

	task automatic send_frame(input logic [7:0] c);
		int n;
		build(c);
		frame_start = 1'b1;
		cfg = c;
		tick;
		frame_start = 1'b0;
		check({7'h00, busy_ff}, 8'h01);
		foreach (dig_q[i])
		begin
			digit_valid = 1'b1;
			digit.value = dig_q[i];
			digit.last = (i == dig_q.size() - 1);
			// a second request with another format while busy must be ignored
			if (i == 1)
			begin
				frame_start = 1'b1;
				cfg = ~c;
			end
			// ready is read settled; the edge after it reads high takes the digit
			n = 0;
			while (digit_ready_ff !== 1'b1)
			begin
				tick;
				n++;
				if (n > 4000) timeout();
			end
			tick;
			if (i == 1)
				frame_start = 1'b0;
		end
		digit_valid = 1'b0;
		n = 0;
		while (busy_ff !== 1'b0)
		begin
			tick;
			n++;
			if (n > 6000) timeout();
		end
		check({7'h00, line_clk_ff}, 8'h01);
		check({7'h00, line_data_ff}, 8'h01);
		tick;
		tick;
		check(8'(exp_q.size()), 8'h00);
		dig_q.delete();
	endtask

	// ----------------------------------------
	// result watcher: oldest noted bit against each sampled bit
	// ----------------------------------------
	always @(negedge clk)
	begin
		if (bit_seen_ff === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(8'h01, 8'h00);
			else
				check({7'h00, bit_val_ff}, {7'h00, exp_q.pop_front()});
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		frame_start = 1'b0;
		cfg = 8'h00;
		digit_valid = 1'b0;
		digit = '0;
		led_req_n = 2'h3;
		fail_count = 0;
		cmp_count = 0;
		cfgs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h00, 8'h8c};
		void'($urandom(7522));
		repeat (8) tick;
		check({7'h00, busy_ff}, 8'h00);
		check({6'h00, line_clk_ff, line_data_ff}, 8'h03);
		reset_n = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			led_req_n = i[1:0];
			repeat (4) tick;
			check({6'h00, led_on_ff}, {6'h00, ~i[1:0]});
		end
		led_req_n = 2'($urandom);
		for (int m = 0; m < 6; m++)
		begin
			if (m == 5)
			begin
				for (int k = 0; k < 16; k++)
					dig_q.push_back(4'(k));
			end
			else
			begin
				for (int k = 0; k < 5; k++)
					dig_q.push_back(4'($urandom));
				if (m == 4)
					dig_q.push_back(DIG_TEN);
				else
				begin
					dig_q.push_back(DIG_STOP);
					dig_q.push_back(4'h3);
				end
			end
			send_frame(cfgs[m]);
		end
		results();
	end
endmodule

// ===== cddf_panel_model.sv
// panel side of the link: samples data on each clock fall
// assumes the framer's registered line outputs share clk
module cddf_panel_model
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic line_clk,
	input  wire logic line_data,
	output logic      bit_seen_ff,
	output logic      bit_val_ff
);
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_prev_ff;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			clk_prev_ff <= 1'b1;
			bit_seen_ff <= 1'b0;
			bit_val_ff  <= 1'b0;
		end
		else
		begin
			clk_prev_ff <= line_clk;
			bit_seen_ff <= clk_prev_ff & ~line_clk;
			bit_val_ff  <= ~line_data;
		end
	end
endmodule

// ===== cddf_pkg.sv
// constants, types and symbol coding for the clock/data digit framer
// assumes one 50 MHz clock; the panel samples the lines on the clock fall
//
// Notes on behaviour
// - five bits: four lsb first, odd parity
// - decimal content digits are zero to nine
// - eleven start, thirteen separator, fifteen stop
// - config bit seven low: stripe style format
// - config bit seven high: raw hex digits
// - config bits three-two select digit translation
// - code 00 drops digits above nine
// - code 01 turns them into separators
// - code 10 sends two decimal digits each
// - code 11 sends separator then value mod ten
// - stripe frame opens with sixteen zero bits
// - start sentinel precedes the content digits
// - stop sentinel follows the content digits
// - check digit xors start and content digits
// - stripe frame closes with sixteen zero bits
// - raw frame has no runs, sentinels, check
// - lines idle high, clock low, data inverted
// - bit is three equal phases, about 1 ms
package cddf_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ   = 50;
	localparam int PHASE_US  = 330;
	localparam int PHASE_CYC = PHASE_US * CLK_MHZ;
	localparam int PHASE_W   = 16;

	// ----------------------------------------
	// configuration byte and led inputs
	// ----------------------------------------
	localparam int         CFG_RAW_BIT = 7;
	localparam int         CFG_XL_HI   = 3;
	localparam int         CFG_XL_LO   = 2;
	localparam logic [1:0] XL_DROP     = 2'h0;
	localparam logic [1:0] XL_SEP      = 2'h1;
	localparam logic [1:0] XL_DEC2     = 2'h2;
	localparam logic [1:0] XL_SEPMOD   = 2'h3;
	localparam int         LED_RED     = 0;
	localparam int         LED_GREEN   = 1;
	localparam int         LED_NUM     = 2;

	// ----------------------------------------
	// digits and symbols
	// ----------------------------------------
	localparam logic [3:0] DIG_ZERO  = 4'h0;
	localparam logic [3:0] DIG_ONE   = 4'h1;
	localparam logic [3:0] DIG_MAX   = 4'h9;
	localparam logic [3:0] DIG_TEN   = 4'ha;
	localparam logic [3:0] DIG_START = 4'hb;
	localparam logic [3:0] DIG_SEP   = 4'hd;
	localparam logic [3:0] DIG_STOP  = 4'hf;
	localparam int         PAT_W     = 16;
	localparam logic [4:0] LEN_SYM   = 5'h05;
	localparam logic [4:0] LEN_RUN   = 5'h10;

	typedef struct packed
	{
		logic [PAT_W-1:0] pat;
		logic [4:0]       len;
	} cddf_sym_type;

	typedef struct packed
	{
		logic       last;
		logic [3:0] value;
	} cddf_digit_type;

	typedef enum logic [2:0]
	{
		ST_IDLE    = 3'h0,
		ST_LEAD    = 3'h1,
		ST_START   = 3'h3,
		ST_CONTENT = 3'h2,
		ST_STOP    = 3'h6,
		ST_LRC     = 3'h7,
		ST_TRAIL   = 3'h5,
		ST_DONE    = 3'h4
	} cddf_frame_state_type;

	typedef enum logic [1:0]
	{
		PH_IDLE  = 2'h0,
		PH_SETUP = 2'h1,
		PH_LOW   = 2'h3,
		PH_HOLD  = 2'h2
	} cddf_phase_type;

	// four data bits lsb first, then odd parity
	function automatic cddf_sym_type cddf_encode(input logic [3:0] d);
		cddf_sym_type s;
		s.pat = {11'h000, ~^d, d};
		s.len = LEN_SYM;
		return s;
	endfunction

endpackage
